// File: pq_regs_pkg.sv
package pq_regs_pkg;

  // ****************************************************
  // Widths
  // ****************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ****************************************************
  // Register word addresses
  // ****************************************************
  localparam logic [11:0] ADDR_STATUS_SECOND = 12'h403;
  localparam logic [11:0] ADDR_EVENT_FLAGS = 12'h404;
  localparam logic [11:0] ADDR_IRQ_ENABLE_FIRST = 12'h405;
  localparam logic [11:0] ADDR_IRQ_ENABLE_SECOND = 12'h406;
  localparam logic [11:0] ADDR_EVENT_ENABLE = 12'h407;
  localparam logic [11:0] ADDR_OVERCURRENT_THRESHOLD = 12'h409;
  localparam logic [11:0] ADDR_OVERCURRENT_CAPTURE_A = 12'h40A;
  localparam logic [11:0] ADDR_OVERCURRENT_CAPTURE_B = 12'h40B;
  localparam logic [11:0] ADDR_OVERCURRENT_CAPTURE_C = 12'h40C;
  localparam logic [11:0] ADDR_OVERCURRENT_CAPTURE_N = 12'h40D;
  localparam logic [11:0] ADDR_USER_LINE_PERIOD = 12'h40E;
  localparam logic [11:0] ADDR_FUNDAMENTAL_LEVEL = 12'h40F;
  localparam logic [11:0] ADDR_SAG_THRESHOLD = 12'h410;
  localparam logic [11:0] ADDR_SAG_CAPTURE_A = 12'h411;
  localparam logic [11:0] ADDR_SAG_CAPTURE_B = 12'h412;
  localparam logic [11:0] ADDR_SAG_CAPTURE_C = 12'h413;
  localparam logic [11:0] ADDR_SURGE_THRESHOLD = 12'h414;
  localparam logic [11:0] ADDR_SURGE_CAPTURE_A = 12'h415;
  localparam logic [11:0] ADDR_SURGE_CAPTURE_B = 12'h416;
  localparam logic [11:0] ADDR_SURGE_CAPTURE_C = 12'h417;
  localparam logic [11:0] ADDR_LINE_PERIOD_A = 12'h418;
  localparam logic [11:0] ADDR_LINE_PERIOD_B = 12'h419;
  localparam logic [11:0] ADDR_LINE_PERIOD_C = 12'h41A;
  localparam logic [11:0] ADDR_LINE_PERIOD_COMBINED = 12'h41B;
  localparam logic [11:0] ADDR_ACTIVE_NOLOAD_THRESHOLD = 12'h41C;
  localparam logic [11:0] ADDR_LAST_DATA = 12'h423;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  localparam logic [31:0] RST_OVERCURRENT_THRESHOLD = 32'h00FFFFFF;
  localparam logic [31:0] RST_USER_LINE_PERIOD = 32'h00500000;
  localparam logic [31:0] RST_FUNDAMENTAL_LEVEL = 32'h00045D45;
  localparam logic [31:0] RST_SAG_THRESHOLD = 32'h00000000;
  localparam logic [31:0] RST_SAG_CAPTURE = 32'h007FFFFF;
  localparam logic [31:0] RST_SURGE_THRESHOLD = 32'h00FFFFFF;
  localparam logic [31:0] RST_LINE_PERIOD = 32'h00A00000;
  localparam logic [31:0] RST_ACTIVE_NOLOAD = 32'h0000FFFF;

  // ****************************************************
  // Serial frame layout
  // ****************************************************
  localparam logic [5:0] CMD_LAST_BIT = 6'h0F;
  localparam logic [5:0] FRAME_LAST_BIT = 6'h2F;
  localparam int CMD_ADDR_LSB = 4;
  localparam int CMD_READ_BIT = 3;

  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_DATA = 2'b01,
    PH_DONE = 2'b10
  } spi_phase_t;

  typedef enum logic {
    CMP_ABOVE = 1'b0,
    CMP_BELOW = 1'b1
  } cmp_mode_t;

endpackage

// File: threshold_capture.sv
`timescale 1ns/1ps
module threshold_capture
  import pq_regs_pkg::*;
#(
  parameter logic [31:0] RESET_VALUE = 32'h00000000,
  parameter cmp_mode_t MODE = CMP_ABOVE
)(
  input wire logic i_clk, // System clock
  input wire logic i_rst_n, // Synchronised reset
  input wire logic i_strobe, // New half-cycle rms value
  input wire logic i_enable, // Capture allowed
  input wire logic [31:0] i_value, // Half-cycle rms
  input wire logic [31:0] i_threshold, // Compare level
  output logic [31:0] o_value // Captured value
);
  typedef struct packed {
    logic [31:0] value;
  } cap_state_t;

  cap_state_t q_reg;
  cap_state_t q_next;
  logic hit;

  always_comb
  begin
    q_next = q_reg;
    if (MODE == CMP_ABOVE)
      hit = i_value > i_threshold;
    else
      hit = i_value < i_threshold;
    if (i_strobe && i_enable && hit)
      q_next.value = i_value;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q_reg <= '{value: RESET_VALUE};
    else
      q_reg <= q_next;
  end

  assign o_value = q_reg.value;
endmodule

// File: spi_frame_engine.sv
`timescale 1ns/1ps
module spi_frame_engine
  import pq_regs_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rst_n, // Synchronised reset
  input wire logic i_sclk, // Serial clock
  input wire logic i_cs_n, // Chip select
  input wire logic i_mosi, // Serial data in
  output logic o_miso, // Serial data out
  output logic o_cmd_valid, // Command word taken
  output logic [11:0] o_addr, // Word address
  output logic o_read, // Frame is a read
  input wire logic [31:0] i_rd_data, // Read word for o_addr
  output logic o_word_valid, // Data word complete
  output logic [31:0] o_word // Received data word
);
  typedef struct packed {
    logic sclk_q;
    spi_phase_t phase;
    logic [5:0] cnt;
    logic [31:0] shift_in;
    logic [31:0] shift_out;
    logic [11:0] addr;
    logic read;
    logic miso;
    logic cmd_valid;
    logic load_pend;
    logic word_valid;
    logic [31:0] word;
  } spi_state_t;

  spi_state_t q_reg;
  spi_state_t q_next;
  logic rise;
  logic fall;

  // SCLK is oversampled, so it must stay below a quarter of the clock
  always_comb
  begin
    q_next = q_reg;
    q_next.cmd_valid = 1'b0;
    q_next.word_valid = 1'b0;
    q_next.sclk_q = i_sclk;
    rise = i_sclk & ~q_reg.sclk_q;
    fall = ~i_sclk & q_reg.sclk_q;
    if (q_reg.load_pend)
    begin
      q_next.shift_out = i_rd_data;
      q_next.load_pend = 1'b0;
    end
    if (i_cs_n)
    begin
      q_next.phase = PH_CMD;
      q_next.cnt = 6'h00;
      q_next.load_pend = 1'b0;
    end
    else if (rise)
    begin
      q_next.shift_in = {q_reg.shift_in[30:0], i_mosi};
      q_next.cnt = q_reg.cnt + 6'h01;
      case (q_reg.phase)
        PH_CMD:
          if (q_reg.cnt == CMD_LAST_BIT)
          begin
            q_next.addr = q_next.shift_in[CMD_ADDR_LSB +: ADDR_W];
            q_next.read = q_next.shift_in[CMD_READ_BIT];
            q_next.cmd_valid = 1'b1;
            q_next.load_pend = 1'b1;
            q_next.phase = PH_DATA;
          end
        PH_DATA:
          if (q_reg.cnt == FRAME_LAST_BIT)
          begin
            q_next.word = q_next.shift_in;
            q_next.word_valid = 1'b1;
            q_next.phase = PH_DONE;
          end
        PH_DONE:
          q_next.cnt = q_reg.cnt;
        default:
          q_next.phase = PH_DONE;
      endcase
    end
    else if (fall && q_reg.phase == PH_DATA)
    begin
      q_next.miso = q_reg.shift_out[31];
      q_next.shift_out = {q_reg.shift_out[30:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q_reg <= '0;
    else
      q_reg <= q_next;
  end

  assign o_miso = q_reg.miso;
  assign o_cmd_valid = q_reg.cmd_valid;
  assign o_addr = q_reg.addr;
  assign o_read = q_reg.read;
  assign o_word_valid = q_reg.word_valid;
  assign o_word = q_reg.word;
endmodule

// File: power_quality_event_registers.sv
// Function
// - Phase overcurrent capture when enabled and above threshold
// - Neutral overcurrent capture uses the shared threshold
// - User period replaces measured period when selected
// - Dip records half-cycle voltage per phase
// - Swell records half-cycle voltage per phase
// - Per-phase and combined line periods, read only
// - Active no-load threshold feeds both power paths
// - Fundamental level feeds fundamental computations
// - Two interrupt enables, one event enable
// - Serial port access; last word kept
`timescale 1ns/1ps
module power_quality_event_registers
  import pq_regs_pkg::*;
(
  input wire logic I_SYS_CLK, // 100 MHz clock
  input wire logic I_RSTN, // Async reset
  input wire logic I_SCLK, // Serial clock
  input wire logic I_CS_N, // Serial select
  input wire logic I_MOSI, // Serial data in
  output logic O_MISO, // Serial data out
  input wire logic I_HALF_CYCLE_STROBE, // New half rms
  input wire logic [31:0] I_HALF_CYCLE_CURRENT_RMS_A, // Ia
  input wire logic [31:0] I_HALF_CYCLE_CURRENT_RMS_B, // Ib
  input wire logic [31:0] I_HALF_CYCLE_CURRENT_RMS_C, // Ic
  input wire logic [31:0] I_HALF_CYCLE_CURRENT_RMS_NEUTRAL, // In
  input wire logic [31:0] I_HALF_CYCLE_VOLTAGE_RMS_A, // Va
  input wire logic [31:0] I_HALF_CYCLE_VOLTAGE_RMS_B, // Vb
  input wire logic [31:0] I_HALF_CYCLE_VOLTAGE_RMS_C, // Vc
  input wire logic I_OVERCURRENT_ENABLE_A, // Phase A
  input wire logic I_OVERCURRENT_ENABLE_B, // Phase B
  input wire logic I_OVERCURRENT_ENABLE_C, // Phase C
  input wire logic I_OVERCURRENT_ENABLE_NEUTRAL, // Neutral
  input wire logic I_USER_PERIOD_SELECT, // Use user period
  input wire logic I_PERIOD_STROBE, // New periods
  input wire logic [31:0] I_MEASURED_PERIOD_A, // Phase A
  input wire logic [31:0] I_MEASURED_PERIOD_B, // Phase B
  input wire logic [31:0] I_MEASURED_PERIOD_C, // Phase C
  input wire logic [31:0] I_MEASURED_PERIOD_COMBINED, // All
  input wire logic [31:0] I_STATUS_SECOND_SET, // Set pulses
  input wire logic [31:0] I_EVENT_FLAGS, // Event levels
  output logic [31:0] O_STATUS_SECOND, // Status bits
  output logic [31:0] O_IRQ_ENABLE_FIRST, // Enable 0
  output logic [31:0] O_IRQ_ENABLE_SECOND, // Enable 1
  output logic [31:0] O_EVENT_ENABLE, // Event enable
  output logic [31:0] O_LINE_PERIOD_USED, // Period in use
  output logic [31:0] O_FUNDAMENTAL_LEVEL, // Level
  output logic [31:0] O_ACTIVE_NOLOAD_THRESHOLD // No-load
);

  // ****************************************************
  // Reset release
  // ****************************************************
  logic rst_meta;
  logic rst_sync_n;

  // Assertion is immediate, release is clean after two edges
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ****************************************************
  // Serial port
  // ****************************************************
  logic cmd_valid;
  logic [11:0] spi_addr;
  logic spi_read;
  logic [31:0] rd_mux;
  logic word_valid;
  logic [31:0] spi_word;

  spi_frame_engine u_spi (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_sync_n),
    .i_sclk(I_SCLK),
    .i_cs_n(I_CS_N),
    .i_mosi(I_MOSI),
    .o_miso(O_MISO),
    .o_cmd_valid(cmd_valid),
    .o_addr(spi_addr),
    .o_read(spi_read),
    .i_rd_data(rd_mux),
    .o_word_valid(word_valid),
    .o_word(spi_word)
  );

  // ****************************************************
  // Register state
  // ****************************************************
  typedef struct packed {
    logic [31:0] status_second;
    logic [31:0] irq_enable_first;
    logic [31:0] irq_enable_second;
    logic [31:0] event_enable;
    logic [31:0] overcurrent_threshold;
    logic [31:0] user_line_period;
    logic [31:0] fundamental_level;
    logic [31:0] sag_threshold;
    logic [31:0] surge_threshold;
    logic [31:0] active_noload_threshold;
    logic [31:0] line_period_a;
    logic [31:0] line_period_b;
    logic [31:0] line_period_c;
    logic [31:0] line_period_combined;
    logic [31:0] line_period_used;
    logic [31:0] last_data;
    logic [31:0] read_snap;
    logic cmd_d;
  } reg_state_t;

  localparam reg_state_t STATE_RESET = '{
    status_second: RST_ZERO,
    irq_enable_first: RST_ZERO,
    irq_enable_second: RST_ZERO,
    event_enable: RST_ZERO,
    overcurrent_threshold: RST_OVERCURRENT_THRESHOLD,
    user_line_period: RST_USER_LINE_PERIOD,
    fundamental_level: RST_FUNDAMENTAL_LEVEL,
    sag_threshold: RST_SAG_THRESHOLD,
    surge_threshold: RST_SURGE_THRESHOLD,
    active_noload_threshold: RST_ACTIVE_NOLOAD,
    line_period_a: RST_LINE_PERIOD,
    line_period_b: RST_LINE_PERIOD,
    line_period_c: RST_LINE_PERIOD,
    line_period_combined: RST_LINE_PERIOD,
    line_period_used: RST_LINE_PERIOD,
    last_data: RST_ZERO,
    read_snap: RST_ZERO,
    cmd_d: 1'b0
  };

  reg_state_t s_reg;
  reg_state_t s_next;

  // ****************************************************
  // Capture units
  // ****************************************************
  logic [31:0] oc_cap_a;
  logic [31:0] oc_cap_b;
  logic [31:0] oc_cap_c;
  logic [31:0] oc_cap_n;
  logic [31:0] sag_cap_a;
  logic [31:0] sag_cap_b;
  logic [31:0] sag_cap_c;
  logic [31:0] surge_cap_a;
  logic [31:0] surge_cap_b;
  logic [31:0] surge_cap_c;

  threshold_capture #(.RESET_VALUE(RST_ZERO), .MODE(CMP_ABOVE)) u_oc_a (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_sync_n),
    .i_strobe(I_HALF_CYCLE_STROBE),
    .i_enable(I_OVERCURRENT_ENABLE_A),
    .i_value(I_HALF_CYCLE_CURRENT_RMS_A),
    .i_threshold(s_reg.overcurrent_threshold),
    .o_value(oc_cap_a)
  );

  threshold_capture #(.RESET_VALUE(RST_ZERO), .MODE(CMP_ABOVE)) u_oc_b (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_sync_n),
    .i_strobe(I_HALF_CYCLE_STROBE),
    .i_enable(I_OVERCURRENT_ENABLE_B),
    .i_value(I_HALF_CYCLE_CURRENT_RMS_B),
    .i_threshold(s_reg.overcurrent_threshold),
    .o_value(oc_cap_b)
  );

  threshold_capture #(.RESET_VALUE(RST_ZERO), .MODE(CMP_ABOVE)) u_oc_c (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_sync_n),
    .i_strobe(I_HALF_CYCLE_STROBE),
    .i_enable(I_OVERCURRENT_ENABLE_C),
    .i_value(I_HALF_CYCLE_CURRENT_RMS_C),
    .i_threshold(s_reg.overcurrent_threshold),
    .o_value(oc_cap_c)
  );

  threshold_capture #(.RESET_VALUE(RST_ZERO), .MODE(CMP_ABOVE)) u_oc_n (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_sync_n),
    .i_strobe(I_HALF_CYCLE_STROBE),
    .i_enable(I_OVERCURRENT_ENABLE_NEUTRAL),
    .i_value(I_HALF_CYCLE_CURRENT_RMS_NEUTRAL),
    .i_threshold(s_reg.overcurrent_threshold),
    .o_value(oc_cap_n)
  );

  // Dip and swell are judged per phase against the shared levels
  threshold_capture #(.RESET_VALUE(RST_SAG_CAPTURE), .MODE(CMP_BELOW))
    u_sag_a (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_sync_n),
    .i_strobe(I_HALF_CYCLE_STROBE),
    .i_enable(1'b1),
    .i_value(I_HALF_CYCLE_VOLTAGE_RMS_A),
    .i_threshold(s_reg.sag_threshold),
    .o_value(sag_cap_a)
  );

  threshold_capture #(.RESET_VALUE(RST_SAG_CAPTURE), .MODE(CMP_BELOW))
    u_sag_b (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_sync_n),
    .i_strobe(I_HALF_CYCLE_STROBE),
    .i_enable(1'b1),
    .i_value(I_HALF_CYCLE_VOLTAGE_RMS_B),
    .i_threshold(s_reg.sag_threshold),
    .o_value(sag_cap_b)
  );

  threshold_capture #(.RESET_VALUE(RST_SAG_CAPTURE), .MODE(CMP_BELOW))
    u_sag_c (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_sync_n),
    .i_strobe(I_HALF_CYCLE_STROBE),
    .i_enable(1'b1),
    .i_value(I_HALF_CYCLE_VOLTAGE_RMS_C),
    .i_threshold(s_reg.sag_threshold),
    .o_value(sag_cap_c)
  );

  threshold_capture #(.RESET_VALUE(RST_ZERO), .MODE(CMP_ABOVE)) u_surge_a (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_sync_n),
    .i_strobe(I_HALF_CYCLE_STROBE),
    .i_enable(1'b1),
    .i_value(I_HALF_CYCLE_VOLTAGE_RMS_A),
    .i_threshold(s_reg.surge_threshold),
    .o_value(surge_cap_a)
  );

  threshold_capture #(.RESET_VALUE(RST_ZERO), .MODE(CMP_ABOVE)) u_surge_b (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_sync_n),
    .i_strobe(I_HALF_CYCLE_STROBE),
    .i_enable(1'b1),
    .i_value(I_HALF_CYCLE_VOLTAGE_RMS_B),
    .i_threshold(s_reg.surge_threshold),
    .o_value(surge_cap_b)
  );

  threshold_capture #(.RESET_VALUE(RST_ZERO), .MODE(CMP_ABOVE)) u_surge_c (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_sync_n),
    .i_strobe(I_HALF_CYCLE_STROBE),
    .i_enable(1'b1),
    .i_value(I_HALF_CYCLE_VOLTAGE_RMS_C),
    .i_threshold(s_reg.surge_threshold),
    .o_value(surge_cap_c)
  );

  // ****************************************************
  // Read decode
  // ****************************************************
  always_comb
  begin
    case (spi_addr)
      ADDR_STATUS_SECOND: rd_mux = s_reg.status_second;
      ADDR_EVENT_FLAGS: rd_mux = I_EVENT_FLAGS;
      ADDR_IRQ_ENABLE_FIRST: rd_mux = s_reg.irq_enable_first;
      ADDR_IRQ_ENABLE_SECOND: rd_mux = s_reg.irq_enable_second;
      ADDR_EVENT_ENABLE: rd_mux = s_reg.event_enable;
      ADDR_OVERCURRENT_THRESHOLD: rd_mux = s_reg.overcurrent_threshold;
      ADDR_OVERCURRENT_CAPTURE_A: rd_mux = oc_cap_a;
      ADDR_OVERCURRENT_CAPTURE_B: rd_mux = oc_cap_b;
      ADDR_OVERCURRENT_CAPTURE_C: rd_mux = oc_cap_c;
      ADDR_OVERCURRENT_CAPTURE_N: rd_mux = oc_cap_n;
      ADDR_USER_LINE_PERIOD: rd_mux = s_reg.user_line_period;
      ADDR_FUNDAMENTAL_LEVEL: rd_mux = s_reg.fundamental_level;
      ADDR_SAG_THRESHOLD: rd_mux = s_reg.sag_threshold;
      ADDR_SAG_CAPTURE_A: rd_mux = sag_cap_a;
      ADDR_SAG_CAPTURE_B: rd_mux = sag_cap_b;
      ADDR_SAG_CAPTURE_C: rd_mux = sag_cap_c;
      ADDR_SURGE_THRESHOLD: rd_mux = s_reg.surge_threshold;
      ADDR_SURGE_CAPTURE_A: rd_mux = surge_cap_a;
      ADDR_SURGE_CAPTURE_B: rd_mux = surge_cap_b;
      ADDR_SURGE_CAPTURE_C: rd_mux = surge_cap_c;
      ADDR_LINE_PERIOD_A: rd_mux = s_reg.line_period_a;
      ADDR_LINE_PERIOD_B: rd_mux = s_reg.line_period_b;
      ADDR_LINE_PERIOD_C: rd_mux = s_reg.line_period_c;
      ADDR_LINE_PERIOD_COMBINED: rd_mux = s_reg.line_period_combined;
      ADDR_ACTIVE_NOLOAD_THRESHOLD:
        rd_mux = s_reg.active_noload_threshold;
      ADDR_LAST_DATA: rd_mux = s_reg.last_data;
      default: rd_mux = RST_ZERO;
    endcase
  end

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb
  begin
    s_next = s_reg;
    s_next.cmd_d = cmd_valid;
    // Read word is frozen one cycle after the shifter loads it
    if (s_reg.cmd_d)
      s_next.read_snap = rd_mux;
    if (I_PERIOD_STROBE)
    begin
      s_next.line_period_a = I_MEASURED_PERIOD_A;
      s_next.line_period_b = I_MEASURED_PERIOD_B;
      s_next.line_period_c = I_MEASURED_PERIOD_C;
      s_next.line_period_combined = I_MEASURED_PERIOD_COMBINED;
    end
    if (word_valid)
    begin
      if (spi_read)
        s_next.last_data = s_reg.read_snap;
      else
        s_next.last_data = spi_word;
    end
    if (word_valid && !spi_read)
    begin
      case (spi_addr)
        ADDR_STATUS_SECOND:
          s_next.status_second = s_reg.status_second & ~spi_word;
        ADDR_IRQ_ENABLE_FIRST: s_next.irq_enable_first = spi_word;
        ADDR_IRQ_ENABLE_SECOND:
          s_next.irq_enable_second = spi_word;
        ADDR_EVENT_ENABLE: s_next.event_enable = spi_word;
        ADDR_OVERCURRENT_THRESHOLD: s_next.overcurrent_threshold = spi_word;
        ADDR_USER_LINE_PERIOD: s_next.user_line_period = spi_word;
        ADDR_FUNDAMENTAL_LEVEL: s_next.fundamental_level = spi_word;
        ADDR_SAG_THRESHOLD: s_next.sag_threshold = spi_word;
        ADDR_SURGE_THRESHOLD: s_next.surge_threshold = spi_word;
        ADDR_ACTIVE_NOLOAD_THRESHOLD:
          s_next.active_noload_threshold = spi_word;
        default: s_next.last_data = s_next.last_data;
      endcase
    end
    // A set arriving with the clear survives it
    s_next.status_second = s_next.status_second | I_STATUS_SECOND_SET;
    if (I_USER_PERIOD_SELECT)
      s_next.line_period_used = s_next.user_line_period;
    else
      s_next.line_period_used = s_next.line_period_combined;
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      s_reg <= STATE_RESET;
    else
      s_reg <= s_next;
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign O_STATUS_SECOND = s_reg.status_second;
  assign O_IRQ_ENABLE_FIRST = s_reg.irq_enable_first;
  assign O_IRQ_ENABLE_SECOND = s_reg.irq_enable_second;
  assign O_EVENT_ENABLE = s_reg.event_enable;
  assign O_LINE_PERIOD_USED = s_reg.line_period_used;
  assign O_FUNDAMENTAL_LEVEL = s_reg.fundamental_level;
  assign O_ACTIVE_NOLOAD_THRESHOLD = s_reg.active_noload_threshold;
endmodule

// File: power_quality_event_registers_sva.sv
`timescale 1ns/1ps
module pq_regs_sva (
  input wire logic I_SYS_CLK, // Clock
  input wire logic I_RSTN, // Reset
  input wire logic I_SCLK, // Serial clock
  input wire logic I_CS_N, // Select
  input wire logic O_MISO, // Serial out
  input wire logic I_USER_PERIOD_SELECT, // User period
  input wire logic I_PERIOD_STROBE, // New periods
  input wire logic [31:0] I_MEASURED_PERIOD_COMBINED, // Period
  input wire logic [31:0] I_STATUS_SECOND_SET, // Set
  input wire logic [31:0] O_STATUS_SECOND, // Status
  input wire logic [31:0] O_IRQ_ENABLE_FIRST, // Enable 0
  input wire logic [31:0] O_IRQ_ENABLE_SECOND, // Enable 1
  input wire logic [31:0] O_EVENT_ENABLE, // Events
  input wire logic [31:0] O_LINE_PERIOD_USED, // Period
  input wire logic [31:0] O_FUNDAMENTAL_LEVEL, // Level
  input wire logic [31:0] O_ACTIVE_NOLOAD_THRESHOLD // No-load
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  // Wait out the two-edge internal reset release
  logic [1:0] age_reg;
  logic up;
  assign up = age_reg == 2'h3;
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    if (!I_RSTN)
      age_reg <= 2'h0;
    else if (!up)
      age_reg <= age_reg + 2'h1;
  property p_status_track;
    up && I_CS_N |-> O_STATUS_SECOND ==
      ($past(O_STATUS_SECOND) | $past(I_STATUS_SECOND_SET));
  endproperty
  a_status_track: assert property (p_status_track)
    else $error("status bits moved");
  property p_enables_hold;
    up && I_CS_N |-> $stable({O_IRQ_ENABLE_FIRST, O_IRQ_ENABLE_SECOND,
      O_EVENT_ENABLE});
  endproperty
  a_enables_hold: assert property (p_enables_hold)
    else $error("enable moved");
  property p_level_hold;
    up && I_CS_N |=> $stable(O_FUNDAMENTAL_LEVEL);
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("level moved");
  property p_noload_hold;
    (up && I_CS_N)[*2] |-> $stable(O_ACTIVE_NOLOAD_THRESHOLD);
  endproperty
  a_noload_hold: assert property (p_noload_hold)
    else $error("no-load moved");
  property p_period_load;
    up && I_PERIOD_STROBE && !I_USER_PERIOD_SELECT |=>
      O_LINE_PERIOD_USED == $past(I_MEASURED_PERIOD_COMBINED);
  endproperty
  a_period_load: assert property (p_period_load)
    else $error("combined period not taken");
  property p_period_user;
    (up && I_USER_PERIOD_SELECT && I_CS_N)[*3] |=> $stable(O_LINE_PERIOD_USED);
  endproperty
  a_period_user: assert property (p_period_user)
    else $error("user period moved");
  property p_miso_idle;
    up && I_CS_N && $past(I_CS_N) |-> $stable(O_MISO);
  endproperty
  a_miso_idle: assert property (p_miso_idle)
    else $error("serial out moved idle");
  property p_miso_fall;
    up && $changed(O_MISO) |-> !I_SCLK && !I_CS_N;
  endproperty
  a_miso_fall: assert property (p_miso_fall)
    else $error("serial out moved on high clock");
endmodule
bind power_quality_event_registers pq_regs_sva chk (.I_SYS_CLK, .I_RSTN,
  .I_SCLK, .I_CS_N, .O_MISO, .I_USER_PERIOD_SELECT, .I_PERIOD_STROBE,
  .I_MEASURED_PERIOD_COMBINED, .I_STATUS_SECOND_SET, .O_STATUS_SECOND,
  .O_IRQ_ENABLE_FIRST, .O_IRQ_ENABLE_SECOND, .O_EVENT_ENABLE,
  .O_LINE_PERIOD_USED, .O_FUNDAMENTAL_LEVEL, .O_ACTIVE_NOLOAD_THRESHOLD);

// File: test_power_quality_event_registers.sv
`timescale 1ns/1ps
module test_power_quality_event_registers;
  import pq_regs_pkg::*;
  logic clk = 0, rst_n = 0, sclk = 0, cs_n = 1, mosi = 0, miso;
  logic hstb = 0, pstb = 0, sel = 0;
  logic [3:0] oc_en = 4'hF;
  logic [31:0] cur [4] = '{default: '0};
  logic [31:0] vlt [3] = '{default: '0};
  logic [31:0] per [4] = '{default: '0};
  logic [31:0] set = '0, ev = '0;
  logic [31:0] o_st, o_e0, o_e1, o_ee, o_pu, o_lv, o_nl;
  logic [31:0] exp_q [$];
  logic [31:0] wv [logic [11:0]];
  int failures = 0, n_compared = 0;

  power_quality_event_registers dut (
    .I_SYS_CLK(clk), .I_RSTN(rst_n), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_MOSI(mosi), .O_MISO(miso), .I_HALF_CYCLE_STROBE(hstb),
    .I_HALF_CYCLE_CURRENT_RMS_A(cur[0]), .I_HALF_CYCLE_CURRENT_RMS_B(cur[1]),
    .I_HALF_CYCLE_CURRENT_RMS_C(cur[2]),
    .I_HALF_CYCLE_CURRENT_RMS_NEUTRAL(cur[3]),
    .I_HALF_CYCLE_VOLTAGE_RMS_A(vlt[0]), .I_HALF_CYCLE_VOLTAGE_RMS_B(vlt[1]),
    .I_HALF_CYCLE_VOLTAGE_RMS_C(vlt[2]), .I_OVERCURRENT_ENABLE_A(oc_en[0]),
    .I_OVERCURRENT_ENABLE_B(oc_en[1]), .I_OVERCURRENT_ENABLE_C(oc_en[2]),
    .I_OVERCURRENT_ENABLE_NEUTRAL(oc_en[3]), .I_USER_PERIOD_SELECT(sel),
    .I_PERIOD_STROBE(pstb), .I_MEASURED_PERIOD_A(per[0]),
    .I_MEASURED_PERIOD_B(per[1]), .I_MEASURED_PERIOD_C(per[2]),
    .I_MEASURED_PERIOD_COMBINED(per[3]), .I_STATUS_SECOND_SET(set),
    .I_EVENT_FLAGS(ev), .O_STATUS_SECOND(o_st), .O_IRQ_ENABLE_FIRST(o_e0),
    .O_IRQ_ENABLE_SECOND(o_e1), .O_EVENT_ENABLE(o_ee),
    .O_LINE_PERIOD_USED(o_pu), .O_FUNDAMENTAL_LEVEL(o_lv),
    .O_ACTIVE_NOLOAD_THRESHOLD(o_nl));

  initial forever #5 clk = ~clk;

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Mode 0 frames, four clocks per phase
  task automatic spi(logic rd, logic [11:0] a, logic [31:0] d);
    logic [47:0] f;
    f = {a, rd, 3'h0, d};
    cs_n = 0;
    for (int i = 47; i >= 0; i--)
    begin
      mosi = f[i];
      repeat (4) @(negedge clk);
      sclk = 1;
      repeat (4) @(negedge clk);
      sclk = 0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1;
    repeat (4) @(negedge clk);
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] e);
    exp_q.push_back(e);
    spi(1'b1, a, 32'h0);
  endtask

  function automatic logic [31:0] rst_val(logic [11:0] a);
    case (a) inside
      12'h404: return ev;
      12'h409, 12'h414: return 32'h00FFFFFF;
      12'h40E: return 32'h00500000;
      12'h40F: return 32'h00045D45;
      [12'h411:12'h413]: return 32'h007FFFFF;
      [12'h418:12'h41B]: return 32'h00A00000;
      12'h41C: return 32'h0000FFFF;
      default: return 32'h0;
    endcase
  endfunction

  // Both lines settle before the serial rise
  initial
  begin
    logic [47:0] fm;
    logic [31:0] fs;
    forever
    begin
      @(negedge cs_n);
      for (int i = 47; i >= 0; i--)
      begin
        @(posedge sclk);
        fm[i] = mosi;
        fs = {fs[30:0], miso};
      end
      if (fm[35])
        check($sformatf("%h", fm[47:36]), fs, exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (80000) @(posedge clk);
    failures++;
    conclude;
  end

  initial
  begin
    logic [31:0] w, r;
    logic [11:0] ad;
    void'($urandom(32'h7070));
    ev = $urandom;
    repeat (3) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    for (int a = 'h403; a <= 'h41C; a++)
    begin
      ad = a[11:0];
      w = $urandom;
      wv[ad] = w;
      rd(ad, rst_val(ad));
      spi(1'b0, ad, w);
      rd(ADDR_LAST_DATA, w);
      r = ad inside {[12'h405:12'h407], 12'h409, [12'h40E:12'h410], 12'h414,
        12'h41C} ? w : rst_val(ad);
      rd(ad, r);
    end
    check("irq enable 0", o_e0, wv[12'h405]);
    check("irq enable 1", o_e1, wv[12'h406]);
    check("event enable", o_ee, wv[12'h407]);
    check("level", o_lv, wv[12'h40F]);
    check("no-load", o_nl, wv[12'h41C]);
    $display("register map test done");
    spi(1'b0, ADDR_OVERCURRENT_THRESHOLD, 32'h100);
    spi(1'b0, ADDR_SAG_THRESHOLD, 32'h200);
    spi(1'b0, ADDR_SURGE_THRESHOLD, 32'h300);
    oc_en = 4'b1101;
    cur = '{32'h101, 32'h101, 32'h100, 32'h200};
    vlt = '{32'h1FF, 32'h301, 32'h250};
    hstb = 1;
    @(negedge clk);
    hstb = 0;
    rd(ADDR_OVERCURRENT_CAPTURE_A, 32'h101);
    rd(ADDR_OVERCURRENT_CAPTURE_B, 32'h0);
    rd(ADDR_OVERCURRENT_CAPTURE_C, 32'h0);
    rd(ADDR_OVERCURRENT_CAPTURE_N, 32'h200);
    rd(ADDR_SAG_CAPTURE_A, 32'h1FF);
    rd(ADDR_SAG_CAPTURE_B, 32'h007FFFFF);
    rd(ADDR_SURGE_CAPTURE_B, 32'h301);
    rd(ADDR_SURGE_CAPTURE_C, 32'h0);
    $display("capture test done");
    foreach (per[i]) per[i] = $urandom;
    pstb = 1;
    @(negedge clk);
    pstb = 0;
    check("period used", o_pu, per[3]);
    for (int i = 0; i < 4; i++)
      rd(ADDR_LINE_PERIOD_A + 12'(i), per[i]);
    sel = 1;
    repeat (4) @(negedge clk);
    check("user period", o_pu, wv[12'h40E]);
    r = $urandom;
    set = r;
    @(negedge clk);
    set = 0;
    @(negedge clk);
    check("status", o_st, r);
    spi(1'b0, ADDR_STATUS_SECOND, 32'h0000FFFF);
    rd(ADDR_STATUS_SECOND, r & 32'hFFFF0000);
    $display("period test done");
    conclude;
  end
endmodule
